// File: rtl/ppm_pkg.sv
// Purpose: constants and carrier types for the program page mapper
// Assumes: 8-bit data-space write strobe, 12-bit program counter
// Notes:   vector and reserved-area bounds are shared with the checker
package ppm_pkg;

   localparam int unsigned PC_W        = 12;
   localparam int unsigned OFS_W       = 11;
   localparam int unsigned PAGE_W      = 2;
   localparam int unsigned PHYS_W      = PAGE_W + OFS_W;
   localparam int unsigned DADDR_W     = 8;
   localparam int unsigned DATA_W      = 8;
   localparam int unsigned STACK_DEPTH = 6;

   localparam logic [DADDR_W-1:0] PAGE_SEL_ADDR = 8'hca;
   localparam logic [PAGE_W-1:0]  STATIC_PAGE   = 2'h1;
   localparam logic [PAGE_W-1:0]  PAGE_RESET    = 2'h0;
   localparam int unsigned        TOP_BIT       = PC_W - 1;

   // areas inside the static page, as program counter values
   localparam logic [PC_W-1:0] USER_LO     = 12'h800;
   localparam logic [PC_W-1:0] USER_HI     = 12'hf9f;
   localparam logic [PC_W-1:0] RSV_LO      = 12'hfa0;
   localparam logic [PC_W-1:0] RSV_HI      = 12'hfef;
   localparam logic [PC_W-1:0] IRQ_VEC_LO  = 12'hff0;
   localparam logic [PC_W-1:0] IRQ_VEC_HI  = 12'hff7;
   localparam logic [PC_W-1:0] NMI_VEC_LO  = 12'hffc;
   localparam logic [PC_W-1:0] NMI_VEC_HI  = 12'hffd;
   localparam logic [PC_W-1:0] RST_VEC_LO  = 12'hffe;
   localparam logic [PC_W-1:0] RST_VEC_HI  = 12'hfff;
   // reserved tops of the selectable pages, as page offsets
   localparam logic [OFS_W-1:0] P0_RSV_HI  = 11'h07f;
   localparam logic [OFS_W-1:0] P23_RSV_HI = 11'h00f;

   typedef enum logic [1:0] {
      PPM_AREA_USER   = 2'b00,
      PPM_AREA_RSV    = 2'b01,
      PPM_AREA_VECTOR = 2'b10
   } ppm_area_t;

   typedef struct packed {
      logic [PAGE_W-1:0] page;
      logic [OFS_W-1:0]  offset;
   } ppm_phys_t;

   typedef struct packed {
      logic               wr_en;
      logic [DADDR_W-1:0] addr;
      logic [DATA_W-1:0]  data;
   } ppm_dwrite_t;

endpackage

// File: rtl/ppm_return_stack.sv
// Purpose: hardware return-address stack for calls and interrupts
// Assumes: push and pop never asserted together by the core
// Notes:   overflow drops the oldest entry, underflow returns zero
`timescale 1ns/10ps
`default_nettype none
module ppm_return_stack
   import ppm_pkg::*;
#(
   parameter int unsigned DEPTH = STACK_DEPTH,
   parameter int unsigned WIDTH = PC_W
) (
   input  wire logic             clk,
   input  wire logic             srst,
   input  wire logic             push,
   input  wire logic [WIDTH-1:0] push_data,
   input  wire logic             pop,
   output logic      [WIDTH-1:0] top,
   output logic                  empty
);

   logic [WIDTH-1:0] level [DEPTH];
   logic [3:0]       used;

   // -------------------------------------------------------------
   // shift storage
   // -------------------------------------------------------------
   // shift form keeps the top in level[0]; no pointer wrap hazard
   genvar g;
   generate
      for (g = 0; g < DEPTH; g++) begin : g_lvl
         logic [WIDTH-1:0] from_up;    // what a push moves in
         logic [WIDTH-1:0] from_down;  // what a pop moves in
         // end levels take fresh data or zero, never a missing neighbour
         if (g == 0) begin : g_head
            assign from_up = push_data;
         end else begin : g_body
            assign from_up = level[g-1];
         end
         if (g == DEPTH - 1) begin : g_tail
            assign from_down = '0;
         end else begin : g_inner
            assign from_down = level[g+1];
         end
         always_ff @(posedge clk) begin
            if (srst) begin
               level[g] <= '0;
            end else if (push) begin
               level[g] <= from_up;
            end else if (pop) begin
               level[g] <= from_down;
            end
         end
      end
   endgenerate

   // fill level, saturating at the depth
   always_ff @(posedge clk) begin
      if (srst) begin
         used <= '0;
      end else if (push && (used != 4'(DEPTH))) begin
         used <= used + 4'h1;
      end else if (pop && (used != '0)) begin
         used <= used - 4'h1;
      end
   end

   assign top   = level[0];
   assign empty = (used == '0);

endmodule
`default_nettype wire

// File: rtl/ppm_mapper.sv
// Purpose: maps a 12-bit fetch counter onto four 2 Kbyte program pages
// Assumes: core and memory on clk; page-select written as data byte
// Notes:   registered outputs, one clock from fetch to physical address
`timescale 1ns/10ps
`default_nettype none
module ppm_mapper
   import ppm_pkg::*;
(
   input  wire logic               clk,
   input  wire logic               srst,
   input  wire logic [PC_W-1:0]    program_counter,
   input  wire logic               fetch_valid,
   input  wire ppm_dwrite_t        dwrite,
   input  wire logic               call_push,
   input  wire logic [PC_W-1:0]    call_return_addr,
   input  wire logic               ret_pop,
   output ppm_phys_t               phys_addr,
   output logic                    phys_valid,
   output ppm_area_t               fetch_area,
   output logic                    vector_irq,
   output logic                    vector_nmi,
   output logic                    vector_reset,
   output logic [PC_W-1:0]         return_addr,
   output logic                    stack_empty
);

   // -------------------------------------------------------------
   // decode helpers
   // -------------------------------------------------------------
   function automatic logic in_range(input logic [PC_W-1:0] a,
                                     input logic [PC_W-1:0] lo,
                                     input logic [PC_W-1:0] hi);
      in_range = (a >= lo) && (a <= hi);
   endfunction

   // area class of a fetch, given the page it lands on
   function automatic ppm_area_t area_of(input logic [PC_W-1:0]   pc,
                                         input logic [PAGE_W-1:0] pg);
      ppm_area_t r;
      logic [OFS_W-1:0] ofs;
      r   = PPM_AREA_USER;
      ofs = pc[OFS_W-1:0];
      if (pc[TOP_BIT]) begin
         if (in_range(pc, IRQ_VEC_LO, IRQ_VEC_HI) ||
             in_range(pc, NMI_VEC_LO, RST_VEC_HI)) begin
            r = PPM_AREA_VECTOR;
         end else if (!in_range(pc, USER_LO, USER_HI)) begin
            r = PPM_AREA_RSV;
         end
      end else if (pg == PAGE_RESET) begin
         if (ofs <= P0_RSV_HI) begin
            r = PPM_AREA_RSV;
         end
      end else if (pg != STATIC_PAGE) begin
         if (ofs <= P23_RSV_HI) begin
            r = PPM_AREA_RSV;
         end
      end else begin
         // static page seen low: user range as its high alias, vectors and the rest reserved
         if (!in_range({1'b1, ofs}, USER_LO, USER_HI)) begin
            r = PPM_AREA_RSV;
         end
      end
      return r;
   endfunction

   // -------------------------------------------------------------
   // page-select register
   // -------------------------------------------------------------
   logic [PAGE_W-1:0] page_number_bits;
   logic [PAGE_W-1:0] next_page;

   // write-only: there is no read path at all, so reads see nothing.
   // reset loads PAGE_RESET, so a fetch low before the first
   // write lands on page 0; software need not write it first
   always_ff @(posedge clk) begin
      if (srst) begin
         page_number_bits <= PAGE_RESET;
      end else if (dwrite.wr_en && (dwrite.addr == PAGE_SEL_ADDR)) begin
         page_number_bits <= dwrite.data[PAGE_W-1:0];
      end
      // no push or pop term here: calls leave the page alone
   end

   // -------------------------------------------------------------
   // address formation
   // -------------------------------------------------------------
   // top bit forces the static page, else the register picks
   always_comb begin
      if (program_counter[TOP_BIT]) begin
         next_page = STATIC_PAGE;
      end else begin
         next_page = page_number_bits;
      end
   end

   // registered outputs; a write on this edge is not yet visible,
   // so the new page applies from the next fetch on
   always_ff @(posedge clk) begin
      if (srst) begin
         phys_addr  <= '0;
         phys_valid <= 1'b0;
         fetch_area <= PPM_AREA_USER;
      end else begin
         phys_addr.page   <= next_page;
         phys_addr.offset <= program_counter[OFS_W-1:0];
         phys_valid       <= fetch_valid;
         fetch_area       <= area_of(program_counter, next_page);
      end
   end

   // vector strobes for the fetch being presented
   always_ff @(posedge clk) begin
      if (srst) begin
         vector_irq   <= 1'b0;
         vector_nmi   <= 1'b0;
         vector_reset <= 1'b0;
      end else begin
         vector_irq   <= fetch_valid &&
                         in_range(program_counter, IRQ_VEC_LO, IRQ_VEC_HI);
         vector_nmi   <= fetch_valid &&
                         in_range(program_counter, NMI_VEC_LO, NMI_VEC_HI);
         vector_reset <= fetch_valid &&
                         in_range(program_counter, RST_VEC_LO, RST_VEC_HI);
      end
   end

   // -------------------------------------------------------------
   // return stack
   // -------------------------------------------------------------
   logic [PC_W-1:0] stack_top;
   logic            stack_none;

   ppm_return_stack #(
      .DEPTH (STACK_DEPTH),
      .WIDTH (PC_W)
   ) u_stack (
      .clk       (clk),
      .srst      (srst),
      .push      (call_push),
      .push_data (call_return_addr),
      .pop       (ret_pop),
      .top       (stack_top),
      .empty     (stack_none)
   );

   // register stack view so outputs come from flip-flops
   always_ff @(posedge clk) begin
      if (srst) begin
         return_addr <= '0;
         stack_empty <= 1'b1;
      end else begin
         return_addr <= stack_top;
         stack_empty <= stack_none;
      end
   end

endmodule
`default_nettype wire

// File: test/ppm_core_model.sv
// Purpose: core side: fetches, data-space writes, calls and returns
// Assumes: inputs change 1 ns after the rising edge of clk
// Notes:   released address and data lines show inverted values; call_return_addr keeps the last
`timescale 1ns/10ps
`default_nettype none
module ppm_core_model
   import ppm_pkg::*;
(
   input  wire logic        clk,
   output logic [PC_W-1:0]  program_counter,
   output logic             fetch_valid,
   output ppm_dwrite_t      dwrite,
   output logic             call_push,
   output logic [PC_W-1:0]  call_return_addr,
   output logic             ret_pop
);
   // idle core at time zero
   initial begin
      program_counter = '0;
      fetch_valid = 1'b0;
      dwrite = '0;
      call_push = 1'b0;
      call_return_addr = '0;
      ret_pop = 1'b0;
   end

   // one request: k 0 fetch, 1 whole-byte write, 2 push, 3 pop
   // whole-byte writes only, no bit set or clear
   task automatic op(input logic [1:0] k, input logic [PC_W-1:0] a,
                     input logic [DATA_W-1:0] d);
      @(posedge clk);
      #1;
      program_counter = a;
      call_return_addr = a;
      dwrite = '{wr_en: k == 2'h1, addr: a[DADDR_W-1:0], data: d};
      fetch_valid = (k == 2'h0);
      call_push = (k == 2'h2);
      ret_pop = (k == 2'h3);
      @(posedge clk);
      #1;
      fetch_valid = 1'b0;
      call_push = 1'b0;
      ret_pop = 1'b0;
      dwrite = '{wr_en: 1'b0, addr: ~a[DADDR_W-1:0], data: ~d};
      program_counter = ~a;
   endtask
endmodule
`default_nettype wire

// File: test/ppm_mapper_checker.sv
// Purpose: concurrent checks on the mapper ports
// Assumes: page select reads as zero after reset
// Notes:   keeps its own shadow of the page select
`timescale 1ns/10ps
`default_nettype none
module ppm_mapper_checker
   import ppm_pkg::*;
(
   input  wire logic             clk,
   input  wire logic             srst,
   input  wire logic [PC_W-1:0]  program_counter,
   input  wire logic             fetch_valid,
   input  wire ppm_dwrite_t      dwrite,
   input  wire logic             call_push,
   input  wire logic [PC_W-1:0]  call_return_addr,
   input  wire logic             ret_pop,
   input  wire ppm_phys_t        phys_addr,
   input  wire logic             phys_valid,
   input  wire ppm_area_t        fetch_area,
   input  wire logic             vector_irq,
   input  wire logic             vector_nmi,
   input  wire logic             vector_reset,
   input  wire logic [PC_W-1:0]  return_addr,
   input  wire logic             stack_empty
);
   logic [PAGE_W-1:0] sel;
   // shadow page select; only the two low data bits count
   always_ff @(posedge clk) begin
      if (srst)
         sel <= PAGE_RESET;
      else if (dwrite.wr_en && dwrite.addr == PAGE_SEL_ADDR)
         sel <= dwrite.data[PAGE_W-1:0];
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);
   a_static_page: assert property (
      fetch_valid && program_counter[TOP_BIT] |=> phys_addr.page == 2'h1)
      else $error("static page not chosen");
   a_low_page: assert property (
      fetch_valid && !program_counter[TOP_BIT]
      |=> phys_addr.page == $past(sel))
      else $error("low range page wrong");
   a_offset_pass: assert property (
      fetch_valid |=> phys_addr.offset == $past(program_counter[OFS_W-1:0]))
      else $error("page offset wrong");
   a_valid_copy: assert property (
      1 |=> phys_valid == $past(fetch_valid))
      else $error("phys_valid wrong");
   a_vec_irq: assert property (
      1 |=> vector_irq == $past(fetch_valid &&
      program_counter inside {[IRQ_VEC_LO:IRQ_VEC_HI]}))
      else $error("irq vector flag wrong");
   a_vec_nmi: assert property (
      1 |=> vector_nmi == $past(fetch_valid &&
      program_counter inside {[NMI_VEC_LO:NMI_VEC_HI]}))
      else $error("nmi vector flag wrong");
   a_vec_reset: assert property (fetch_valid &&
      program_counter >= RST_VEC_LO |=> vector_reset)
      else $error("reset vector flag missing");
   a_rsv_area: assert property (fetch_valid &&
      program_counter inside {[RSV_LO:RSV_HI]} |=> fetch_area == PPM_AREA_RSV)
      else $error("reserved area not flagged");
   a_stack_push: assert property (
      call_push ##1 !(call_push || ret_pop)
      |=> return_addr == $past(call_return_addr, 2) && !stack_empty)
      else $error("pushed address not on top");
   c_page3: cover property (fetch_valid && !program_counter[TOP_BIT] && &sel);
   c_reset_vec: cover property (vector_reset);
   c_pop: cover property (ret_pop && !stack_empty);
endmodule
bind ppm_mapper ppm_mapper_checker chk_i (.clk(clk), .srst(srst),
   .program_counter(program_counter), .fetch_valid(fetch_valid),
   .dwrite(dwrite), .call_push(call_push), .ret_pop(ret_pop),
   .call_return_addr(call_return_addr), .phys_addr(phys_addr),
   .phys_valid(phys_valid), .fetch_area(fetch_area),
   .vector_irq(vector_irq), .vector_nmi(vector_nmi),
   .vector_reset(vector_reset), .return_addr(return_addr),
   .stack_empty(stack_empty));
`default_nettype wire

// File: test/program_page_mapper_bench.sv
// Purpose: directed run of page writes, fetches and stack use
// Assumes: page select cleared by reset
// Notes:   ff8-ffb left out, its area class is not pinned down
`timescale 1ns/10ps
`default_nettype none
module program_page_mapper_bench
   import ppm_pkg::*;
;
   logic clk, srst, fv, cp, rp, phv, vi, vn, vr, se;
   logic [PC_W-1:0] pc, cra, ra;
   ppm_dwrite_t dw;
   ppm_phys_t ph;
   ppm_area_t fa, ea;
   int mismatches, check_count;
   logic [PC_W-1:0] va [9] = '{12'hf9f, 12'hfa0, 12'hfef, 12'hff0,
      12'hff7, 12'hffc, 12'hfff, 12'h00f, 12'h010};

   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   ppm_core_model mdl (.clk(clk), .program_counter(pc), .fetch_valid(fv),
      .dwrite(dw), .call_push(cp), .call_return_addr(cra), .ret_pop(rp));
   ppm_mapper uut (.clk(clk), .srst(srst), .program_counter(pc),
      .fetch_valid(fv), .dwrite(dw), .call_push(cp),
      .call_return_addr(cra), .ret_pop(rp), .phys_addr(ph),
      .phys_valid(phv), .fetch_area(fa), .vector_irq(vi),
      .vector_nmi(vn), .vector_reset(vr), .return_addr(ra),
      .stack_empty(se));

   task automatic chk(input string n, input logic [15:0] s,
                      input logic [15:0] e);
      check_count++;
      if (s !== e) begin
         mismatches++;
         $display("[ERR] %s expected %h seen %h", n, e, s);
      end
   endtask

   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   // hang guard
   initial begin
      repeat (3000) @(posedge clk);
      mismatches++;
      report_and_stop();
   end

   initial begin
      srst = 1'b1;
      repeat (6) @(posedge clk);
      #1 srst = 1'b0;
      chk("stack_empty", 16'(se), 16'h1);
      // each page through static code, write, fetch low
      for (int p = 0; p < 4; p++) begin
         mdl.op(2'h0, 12'hf00, 8'h00);
         mdl.op(2'h1, 12'h0ca, {6'h2a, p[1:0]});
         mdl.op(2'h1, 12'h0cb, 8'hff);
         mdl.op(2'h0, 12'h7f0 - 12'(p), 8'h00);
         chk("page", 16'(ph.page), 16'(p));
         chk("offset", 16'(ph.offset), 16'h7f0 - 16'(p));
         chk("valid", 16'(phv), 16'h1);
         mdl.op(2'h2, 12'h450 + 12'(p), 8'h00);
         mdl.op(2'h0, 12'h0ff, 8'h00);
         chk("page_kept", 16'(ph.page), 16'(p));
         chk("ret_top", 16'(ra), 16'h450 + 16'(p));
         mdl.op(2'h0, 12'h8a5, 8'h00);
         chk("static", 16'(ph.page), 16'(STATIC_PAGE));
         chk("st_ofs", 16'(ph.offset), 16'h0a5);
      end
      // vectors and areas, page 3 still selected
      for (int i = 0; i < 9; i++) begin
         mdl.op(2'h0, va[i], 8'h00);
         ea = va[i] > RSV_HI ? PPM_AREA_VECTOR :
              va[i] >= RSV_LO ? PPM_AREA_RSV :
              (!va[i][11] && va[i] <= 12'h00f) ? PPM_AREA_RSV : PPM_AREA_USER;
         chk("area", 16'(fa), 16'(ea));
         chk("irq", 16'(vi), 16'(va[i] inside {[12'hff0:12'hff7]}));
         chk("nmi", 16'(vn), 16'(va[i] inside {[12'hffc:12'hffd]}));
         chk("rst", 16'(vr), 16'(va[i] >= 12'hffe));
      end
      repeat (4) mdl.op(2'h3, 12'h000, 8'h00);
      mdl.op(2'h0, 12'h020, 8'h00);
      chk("empty_again", 16'(se), 16'h1);
      chk("page_after_pop", 16'(ph.page), 16'h3);
      // seven pushes keep the newest six; pops past empty give zero
      for (int i = 1; i <= 7; i++) begin
         mdl.op(2'h2, 12'h100 + 12'(i), 8'h00);
      end
      repeat (5) mdl.op(2'h3, 12'h000, 8'h00);
      mdl.op(2'h0, 12'h020, 8'h00);
      chk("ret_sixth", 16'(ra), 16'h102);
      chk("not_empty", 16'(se), 16'h0);
      repeat (2) mdl.op(2'h3, 12'h000, 8'h00);
      mdl.op(2'h0, 12'h020, 8'h00);
      chk("ret_under", 16'(ra), 16'h000);
      chk("empty_under", 16'(se), 16'h1);
      // mid-run reset with a pushed entry: stack view and page cleared
      mdl.op(2'h2, 12'h3c3, 8'h00);
      @(posedge clk);
      #1 srst = 1'b1;
      repeat (2) @(posedge clk);
      #1 srst = 1'b0;
      chk("rst_empty", 16'(se), 16'h1);
      chk("rst_ret", 16'(ra), 16'h000);
      chk("rst_valid", 16'(phv), 16'h0);
      mdl.op(2'h0, 12'h020, 8'h00);
      chk("rst_page", 16'(ph.page), 16'(PAGE_RESET));
      report_and_stop();
   end
endmodule
`default_nettype wire
